// ---- core/cau_map.svh ----
// Register offsets, bit positions, reset values and timing counts
`ifndef CAU_MAP_SVH
`define CAU_MAP_SVH

`define CAU_OFS_CTRL      5'h00
`define CAU_OFS_AMODE     5'h01
`define CAU_OFS_CNT_LO    5'h02
`define CAU_OFS_CNT_HI    5'h03
`define CAU_OFS_MOD0      5'h04
`define CAU_MOD_STRIDE    3
`define CAU_SUB_MODE      0
`define CAU_SUB_LO        1
`define CAU_SUB_HI        2

`define CAU_CTRL_CF       7
`define CAU_CTRL_CR       6

`define CAU_AMODE_IDLE_SUSPEND_BIT    7
`define CAU_AMODE_WATCHDOG_ENABLE_BIT    6
`define CAU_AMODE_WATCHDOG_LOCK_BIT   5
`define CAU_AMODE_CPS_HI  3
`define CAU_AMODE_CPS_LO  1
`define CAU_AMODE_ECF     0

`define CAU_MM_P16        7
`define CAU_MM_ECOM       6
`define CAU_MM_CAPP       5
`define CAU_MM_CAPN       4
`define CAU_MM_MAT        3
`define CAU_MM_TOG        2
`define CAU_MM_PWM        1
`define CAU_MM_ECCF       0

`define CAU_WDT_MODE      8'h48
`define CAU_WDT_MODULE    2
`define CAU_RST_WATCHDOG_ENABLE_BIT      1'b1
`define CAU_RST_CPS       3'h0
`define CAU_RST_BYTE      8'h00

`define CAU_CPS_DIV12     3'h0
`define CAU_CPS_DIV4      3'h1
`define CAU_CPS_T0        3'h2
`define CAU_CPS_ECI       3'h3
`define CAU_CPS_SYS       3'h4
`define CAU_CPS_EXT8      3'h5

`define CAU_DIV12_LAST    4'hB
`define CAU_DIV4_MASK     4'h3

`endif

// ---- core/cau_pkg.sv ----
// Types shared by the counter array unit
package cau_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cau_bus_req_t;

    typedef enum logic [2:0] {
        CAU_M_OFF,
        CAU_M_SWT,
        CAU_M_HSO,
        CAU_M_FRQ,
        CAU_M_PW8,
        CAU_M_PW16
    } cau_mode_t;

endpackage

// ---- core/cau_top.sv ----
// Counter array unit: shared counter, compare modules and watchdog
//
// Added by the designer: the placing of the registers and strobed register access.
`include "cau_map.svh"

module cau_top
    import cau_pkg::*;
#(
    parameter int NUM_MOD = 3
)(
    input  wire logic               core_clk_i,
    input  wire logic               rst_n_i,
    input  wire logic [4:0]         addr_i,
    input  wire logic [7:0]         wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [7:0]         rdata_o,
    input  wire logic               idle_i,
    input  wire logic               t0_ovf_i,
    input  wire logic               ext_osc_tick_i,
    input  wire logic               eci_pin_i,
    output logic      [NUM_MOD-1:0] module_output_pin_o,
    output logic                    irq_o,
    output logic                    sys_reset_o
);

    timeunit 1ns;
    timeprecision 1ps;

    // Control register has room for six flags beside its two top bits
    if (NUM_MOD < 3 || NUM_MOD > 6)
    begin : g_check
        $error("NUM_MOD must lie between 3 and 6");
    end

    function automatic logic [4:0] mod_addr(input int n, input int k);
        return 5'(32'(`CAU_OFS_MOD0) + `CAU_MOD_STRIDE * n + k);
    endfunction

    // Mode decode shared by every module
    function automatic cau_mode_t mode_of(input logic [7:0] m);
        logic ecom;
        logic mat;
        logic tog;
        logic pwm;
        ecom = m[`CAU_MM_ECOM];
        mat  = m[`CAU_MM_MAT];
        tog  = m[`CAU_MM_TOG];
        pwm  = m[`CAU_MM_PWM];
        if (!ecom)
            return CAU_M_OFF;
        else if (tog && pwm)
            return CAU_M_FRQ;
        else if (pwm)
            return m[`CAU_MM_P16] ? CAU_M_PW16 : CAU_M_PW8;
        else if (mat)
            return tog ? CAU_M_HSO : CAU_M_SWT;
        else
            return CAU_M_OFF;
    endfunction

    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    cau_bus_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    wire wr_ctrl  = req.wr && req.addr == `CAU_OFS_CTRL;
    wire wr_amode = req.wr && req.addr == `CAU_OFS_AMODE;
    wire wr_cnlo  = req.wr && req.addr == `CAU_OFS_CNT_LO;
    wire wr_cnhi  = req.wr && req.addr == `CAU_OFS_CNT_HI;

    logic        cf_q;
    logic        cr_q;
    logic        idle_suspend_bit_q;
    logic        watchdog_enable_bit_q;
    logic        watchdog_lock_bit_q;
    logic [2:0]  cps_q;
    logic        ecf_q;
    logic [15:0] cnt_q;
    logic [7:0]  snap_q;
    logic [3:0]  pre_q;
    logic [2:0]  eci_q;
    logic [NUM_MOD-1:0] flag_q;
    logic [7:0]  mode_q [NUM_MOD];
    logic [7:0]  lo_q   [NUM_MOD];
    logic [7:0]  hi_q   [NUM_MOD];
    logic [NUM_MOD-1:0] out_q;
    logic [NUM_MOD-1:0] flag_set;
    logic [NUM_MOD-1:0] eccf;
    logic [7:0]  rdata_q;
    logic        sysrst_q;

    wire wdt_en = watchdog_enable_bit_q | watchdog_lock_bit_q;
    // Counter forced on by the watchdog; the run bit keeps its own value
    wire run    = (cr_q | wdt_en) && !(idle_suspend_bit_q && idle_i);

    // ECI sampled twice; edge taken from stages two and three
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            eci_q <= 3'h7;
        else
            eci_q <= {eci_q[1:0], eci_pin_i};
    end
    wire eci_fall = eci_q[2] && !eci_q[1];

    wire pre_last = pre_q == `CAU_DIV12_LAST;
    logic tb_tick;
    always_comb
    begin
        case (cps_q)
            `CAU_CPS_DIV12: tb_tick = pre_last;
            `CAU_CPS_DIV4:  tb_tick = (pre_q & `CAU_DIV4_MASK) == `CAU_DIV4_MASK;
            `CAU_CPS_T0:    tb_tick = t0_ovf_i;
            `CAU_CPS_ECI:   tb_tick = eci_fall;
            `CAU_CPS_SYS:   tb_tick = 1'b1;
            `CAU_CPS_EXT8:  tb_tick = ext_osc_tick_i;
            default:        tb_tick = 1'b0;
        endcase
    end

    wire        tick   = run && tb_tick;
    wire [15:0] cnt_nx = cnt_q + 16'h0001;
    wire        cf_set = tick && cnt_q == 16'hFFFF;
    wire        lo_ovf = tick && cnt_q[7:0] == 8'hFF;

    // Reset fires on low overflow while the watchdog byte matches high
    wire wdt_hit = wdt_en && lo_ovf
                   && hi_q[`CAU_WDT_MODULE] == cnt_q[15:8];
    wire wdt_force = wr_ctrl && wdt_en
                     && wdata_i[`CAU_WDT_MODULE];

    // Prescaler never stops, so the first tick after a restart may come early
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pre_q <= 4'h0;
        else
            pre_q <= pre_last ? 4'h0 : pre_q + 4'h1;
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= 16'h0000;
            snap_q <= `CAU_RST_BYTE;
        end
        else
        begin
            if (wr_cnlo && !wdt_en)
                cnt_q[7:0] <= wdata_i;
            else if (wr_cnhi && !wdt_en)
                cnt_q[15:8] <= wdata_i;
            else if (tick)
                cnt_q <= cnt_nx;
            // Low-byte read freezes the high byte for a clean 16-bit read
            if (req.rd && req.addr == `CAU_OFS_CNT_LO)
                snap_q <= cnt_q[15:8];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cf_q    <= 1'b0;
            cr_q    <= 1'b0;
            flag_q  <= '0;
            idle_suspend_bit_q  <= 1'b0;
            watchdog_enable_bit_q  <= `CAU_RST_WATCHDOG_ENABLE_BIT;
            watchdog_lock_bit_q <= 1'b0;
            cps_q   <= `CAU_RST_CPS;
            ecf_q   <= 1'b0;
        end
        else
        begin
            // Hardware set beats a software clear in the same cycle
            cf_q   <= cf_set | (wr_ctrl ? wdata_i[`CAU_CTRL_CF] : cf_q);
            flag_q <= flag_set | (wr_ctrl ? wdata_i[NUM_MOD-1:0] : flag_q);
            if (wr_ctrl)
                cr_q <= wdata_i[`CAU_CTRL_CR];
            if (wr_amode)
            begin
                watchdog_enable_bit_q  <= wdata_i[`CAU_AMODE_WATCHDOG_ENABLE_BIT];
                watchdog_lock_bit_q <= watchdog_lock_bit_q | wdata_i[`CAU_AMODE_WATCHDOG_LOCK_BIT];
                ecf_q   <= wdata_i[`CAU_AMODE_ECF];
                if (!wdt_en)
                begin
                    idle_suspend_bit_q <= wdata_i[`CAU_AMODE_IDLE_SUSPEND_BIT];
                    cps_q  <= wdata_i[`CAU_AMODE_CPS_HI:`CAU_AMODE_CPS_LO];
                end
            end
        end
    end

    for (genvar n = 0; n < NUM_MOD; n++)
    begin : g_mod
        // Watchdog pins module two to timer mode, ignoring its mode writes
        wire       wd     = (n == `CAU_WDT_MODULE) && wdt_en;
        wire [7:0] eff    = wd ? `CAU_WDT_MODE : mode_q[n];
        cau_mode_t md;
        assign md = mode_of(eff);
        wire       mat    = eff[`CAU_MM_MAT];
        wire       wr_md  = req.wr && req.addr == mod_addr(n, `CAU_SUB_MODE);
        wire       wr_lo  = req.wr && req.addr == mod_addr(n, `CAU_SUB_LO);
        wire       wr_hi  = req.wr && req.addr == mod_addr(n, `CAU_SUB_HI);
        wire       m16    = cnt_nx == {hi_q[n], lo_q[n]};
        wire       m8     = cnt_nx[7:0] == lo_q[n];
        wire       ovf8   = cnt_nx[7:0] == 8'h00;
        wire       ovf16  = cnt_nx == 16'h0000;
        logic      out_d;
        logic [7:0] lo_d;
        logic [7:0] hi_d;
        logic [7:0] md_d;

        assign eccf[n] = eff[`CAU_MM_ECCF];
        assign flag_set[n] = tick && !wd && (
              ((md == CAU_M_SWT || md == CAU_M_HSO) && m16)
            || (md == CAU_M_PW16 && mat && m16)
            || ((md == CAU_M_FRQ || md == CAU_M_PW8) && mat && m8));

        always_comb
        begin
            out_d = out_q[n];
            if (eff[`CAU_MM_PWM] && !eff[`CAU_MM_ECOM])
                out_d = 1'b0;
            else if (tick)
            begin
                case (md)
                    CAU_M_HSO:  if (m16) out_d = !out_q[n];
                    CAU_M_FRQ:  if (m8) out_d = !out_q[n];
                    // Zero compare byte means full duty: wrap sets, not clears
                    CAU_M_PW8:
                        if (ovf8) out_d = hi_q[n] == 8'h00;
                        else if (m8) out_d = 1'b1;
                    CAU_M_PW16:
                        if (ovf16) out_d = {hi_q[n], lo_q[n]} == 16'h0000;
                        else if (m16) out_d = 1'b1;
                    default: out_d = out_q[n];
                endcase
            end
        end

        always_comb
        begin
            lo_d = lo_q[n];
            // Software write beats the hardware update in one cycle
            if (wr_lo)
                lo_d = wdata_i;
            else if (tick && md == CAU_M_FRQ && m8)
                lo_d = lo_q[n] + hi_q[n];
            else if (tick && md == CAU_M_PW8 && ovf8)
                lo_d = hi_q[n];
        end

        always_comb
        begin
            hi_d = hi_q[n];
            if (wr_hi)
                hi_d = wd ? cnt_q[15:8] + lo_q[n] : wdata_i;
        end

        always_comb
        begin
            md_d = mode_q[n];
            // Low write disarms, high write re-arms: no torn compare value
            if (wr_md && !wd)
                md_d = wdata_i;
            else if (wr_lo && !wd)
                md_d[`CAU_MM_ECOM] = 1'b0;
            else if (wr_hi && !wd)
                md_d[`CAU_MM_ECOM] = 1'b1;
        end

        always_ff @(posedge core_clk_i or negedge rst_n)
        begin
            if (!rst_n)
            begin
                out_q[n]  <= 1'b0;
                lo_q[n]   <= `CAU_RST_BYTE;
                hi_q[n]   <= `CAU_RST_BYTE;
                mode_q[n] <= `CAU_RST_BYTE;
            end
            else
            begin
                out_q[n]  <= out_d;
                lo_q[n]   <= lo_d;
                hi_q[n]   <= hi_d;
                mode_q[n] <= md_d;
            end
        end
    end

    // Read mux; module registers decoded by index
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        case (req.addr)
            `CAU_OFS_CTRL:   rd_mux = {cf_q, cr_q, 6'(flag_q)};
            `CAU_OFS_AMODE:  rd_mux = {idle_suspend_bit_q, watchdog_enable_bit_q, watchdog_lock_bit_q, 1'b0, cps_q, ecf_q};
            `CAU_OFS_CNT_LO: rd_mux = cnt_q[7:0];
            `CAU_OFS_CNT_HI: rd_mux = snap_q;
            default:
                for (int n = 0; n < NUM_MOD; n++)
                begin
                    if (req.addr == mod_addr(n, `CAU_SUB_MODE)) rd_mux = mode_q[n];
                    if (req.addr == mod_addr(n, `CAU_SUB_LO))   rd_mux = lo_q[n];
                    if (req.addr == mod_addr(n, `CAU_SUB_HI))   rd_mux = hi_q[n];
                end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q  <= 8'h00;
            sysrst_q <= 1'b0;
        end
        else
        begin
            // Zero outside the answer cycle so stale data never lingers
            rdata_q  <= req.rd ? rd_mux : 8'h00;
            sysrst_q <= wdt_hit | wdt_force;
        end
    end

    // Reset request only; the system reset itself lies outside
    assign rdata_o             = rdata_q;
    assign sys_reset_o         = sysrst_q;
    assign module_output_pin_o = out_q;
    assign irq_o = (cf_q && ecf_q) || |(flag_q & eccf);

endmodule // cau_top

// ---- sim/cau_top_sva.sv ----
// Port assertions for the counter array unit
module cau_top_sva #(
    parameter int NUM_MOD = 3
)(
    input wire logic               core_clk_i,
    input wire logic               rst_n_i,
    input wire logic [4:0]         addr_i,
    input wire logic [7:0]         wdata_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire logic [7:0]         rdata_o,
    input wire logic [NUM_MOD-1:0] module_output_pin_o,
    input wire logic               irq_o,
    input wire logic               sys_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] LAST_ADDR = 5'(3 + 3 * NUM_MOD);
    logic wde_q;
    logic lck_q;
    // Shadow of the enable; lock keeps it on until reset
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wde_q <= 1'b1;
            lck_q <= 1'b0;
        end
        else if (wr_i && addr_i == 5'h01)
        begin
            wde_q <= wdata_i[6] | wdata_i[5] | lck_q;
            lck_q <= lck_q | wdata_i[5];
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_force;
        wr_i && addr_i == 5'h00 && wdata_i[2] && wde_q;
    endsequence
    sequence s_quiet;
        !sys_reset_o && !irq_o && module_output_pin_o == '0;
    endsequence
    chk_force_reset: assert property (s_force |=> sys_reset_o)
        else $error("forced watchdog reset missing");
    chk_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o)
        else $error("reset request longer than one cycle");
    chk_reset_needs_wd: assert property (sys_reset_o |-> $past(wde_q))
        else $error("reset request with watchdog off");
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    chk_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > LAST_ADDR |->
        rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_unused: assert property ($past(rd_i && addr_i == 5'h00) |->
        rdata_o[5:3] == 3'h0)
        else $error("control unused bits set");
    chk_amode_gap: assert property ($past(rd_i && addr_i == 5'h01) |-> !rdata_o[4])
        else $error("array mode gap bit set");
    chk_release_quiet: assert property ($rose(rst_n_i) |-> s_quiet [*2])
        else $error("outputs active during reset release");
endmodule // cau_top_sva

bind cau_top cau_top_sva #(.NUM_MOD(NUM_MOD)) u_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .module_output_pin_o(module_output_pin_o),
    .irq_o(irq_o), .sys_reset_o(sys_reset_o)
);

// ---- sim/test_cau_top.sv ----
// Self-checking bench for the counter array unit
module test_cau_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst_n;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [2:0] pin;
    logic       irq;
    logic       sreset;
    logic [7:0] d;
    int         fails = 0;
    int         samples_checked = 0;
    int         n;
    int         h;
    int         t;

    always #10 clk = ~clk;

    cau_top u_dut (
        .core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .idle_i(1'b0), .t0_ovf_i(1'b0),
        .ext_osc_tick_i(1'b0), .eci_pin_i(1'b0), .module_output_pin_o(pin),
        .irq_o(irq), .sys_reset_o(sreset)
    );

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Data only stands in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkr(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // Looks before the first edge: a forced request stands one cycle only
    task automatic wait_rst(input int lim, output int c);
        c = 0;
        #1;
        while (sreset !== 1'b1 && c < lim)
        begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    task automatic wait_chg(input int i, output int c);
        logic p;
        p = pin[i];
        c = 0;
        while (pin[i] === p && c < 200)
        begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    task automatic measure(input int i, input int len, output int hn, output int tg);
        logic p;
        hn = 0;
        tg = 0;
        @(posedge clk);
        #1;
        p = pin[i];
        repeat (len)
        begin
            @(posedge clk);
            #1;
            if (pin[i] === 1'b1)
                hn++;
            if (pin[i] !== p)
                tg++;
            p = pin[i];
        end
    endtask

    task automatic summarize();
        $display("samples_checked=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence needs about 12300 cycles
    initial
    begin
        repeat (30000) @(posedge clk);
        fails++;
        summarize();
    end

    initial
    begin
        rst_n = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        do_reset();
        rd_reg(5'h01, d);
        chk8(d, 8'h40);
        rd_reg(5'h00, d);
        chk8(d, 8'h00);
        rd_reg(5'h1F, d);
        chk8(d, 8'h00);
        wait_rst(3200, n);
        chkr(n, 3000, 3100);
        do_reset();
        wr_reg(5'h00, 8'h04);
        wait_rst(5, n);
        chkr(n, 0, 1);
        do_reset();
        wr_reg(5'h01, 8'h00);
        wr_reg(5'h01, 8'h08);
        wr_reg(5'h0B, 8'h02);
        wr_reg(5'h01, 8'h48);
        wr_reg(5'h01, 8'hC0);
        rd_reg(5'h01, d);
        chk8(d, 8'h48);
        wr_reg(5'h0C, 8'h00);
        wait_rst(900, n);
        chkr(n, 500, 790);
        do_reset();
        wr_reg(5'h01, 8'h20);
        wr_reg(5'h01, 8'h00);
        wr_reg(5'h00, 8'h04);
        wait_rst(5, n);
        chkr(n, 0, 1);
        do_reset();
        wr_reg(5'h01, 8'h00);
        wr_reg(5'h00, 8'h04);
        wait_rst(4000, n);
        chkr(n, 4000, 4000);
        wr_reg(5'h01, 8'h08);
        wr_reg(5'h00, 8'h00);
        wr_reg(5'h02, 8'h00);
        wr_reg(5'h03, 8'h00);
        wr_reg(5'h04, 8'h4D);
        wr_reg(5'h05, 8'h20);
        rd_reg(5'h04, d);
        chk8(d, 8'h0D);
        wr_reg(5'h06, 8'h00);
        rd_reg(5'h04, d);
        chk8(d, 8'h4D);
        wr_reg(5'h00, 8'h40);
        wait_chg(0, n);
        chkr(n, 30, 35);
        rd_reg(5'h00, d);
        chk8(d, 8'h41);
        chk8({7'h00, irq}, 8'h01);
        wr_reg(5'h00, 8'h40);
        #1;
        chk8({7'h00, irq}, 8'h00);
        wr_reg(5'h08, 8'h80);
        wr_reg(5'h09, 8'hC0);
        wr_reg(5'h07, 8'h42);
        repeat (300) @(posedge clk);
        measure(1, 512, h, t);
        chkr(h, 128, 128);
        wr_reg(5'h08, 8'h80);
        measure(1, 512, h, t);
        chkr(h, 0, 1);
        wr_reg(5'h05, 8'h00);
        wr_reg(5'h06, 8'h10);
        wr_reg(5'h04, 8'h46);
        repeat (300) @(posedge clk);
        measure(0, 512, h, t);
        chkr(t, 32, 32);
        wr_reg(5'h06, 8'h00);
        repeat (600) @(posedge clk);
        measure(0, 512, h, t);
        chkr(t, 2, 2);
        wr_reg(5'h00, 8'h00);
        wr_reg(5'h02, 8'h00);
        wr_reg(5'h03, 8'hFE);
        wr_reg(5'h0B, 8'h00);
        wr_reg(5'h0C, 8'hFF);
        wr_reg(5'h0A, 8'hCB);
        wr_reg(5'h08, 8'h00);
        wr_reg(5'h09, 8'hFF);
        wr_reg(5'h07, 8'h48);
        wr_reg(5'h01, 8'h09);
        wr_reg(5'h00, 8'h40);
        measure(2, 1024, h, t);
        chkr(h, 250, 260);
        rd_reg(5'h00, d);
        chk8(d, 8'hC6);
        chk8({7'h00, pin[1]}, 8'h00);
        chk8({7'h00, irq}, 8'h01);
        summarize();
    end
endmodule // test_cau_top
